//--- common/lds_cfg.svh
// Constants of the LED driver power-up and fault sequencer
`ifndef LDS_CFG_SVH
`define LDS_CFG_SVH

// ----------------------------------------------------------------
// Clock and channel count
// ----------------------------------------------------------------
`define LDS_CLK_MHZ 25
`define LDS_NCH 2

// ----------------------------------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------------------------------
`define LDS_FIRST_HIGH_NS 2000
`define LDS_FIRST_HIGH_CYC ((`LDS_FIRST_HIGH_NS * `LDS_CLK_MHZ + 999) / 1000)
`define LDS_DET_MIN_CYC 3000
`define LDS_DET_MAX_CYC 4000
`define LDS_DET_CYC 3500
`define LDS_GF1_CYC 10000
`define LDS_GF2_NS 3000
`define LDS_GF2_CYC ((`LDS_GF2_NS * `LDS_CLK_MHZ) / 1000)
`define LDS_ENLOW_CYC 32750
`define LDS_TMR_W 16

`endif

//--- common/lds_pkg.sv
// Types of the LED driver power-up and fault sequencer
`default_nettype none
`include "lds_cfg.svh"

package lds_pkg;

  // Gray along off, gate, detect, soft start, run
  typedef enum logic [2:0] {
    LDS_OFF    = 3'b000,
    LDS_GATE   = 3'b001,
    LDS_DETECT = 3'b011,
    LDS_SOFT   = 3'b010,
    LDS_RUN    = 3'b110,
    LDS_FAULT  = 3'b100,
    LDS_SLEEP  = 3'b101
  } lds_state_e;

  typedef enum logic [1:0] {
    LDS_CH_NONE   = 2'h0,
    LDS_CH_SHORT  = 2'h1,
    LDS_CH_UNUSED = 2'h2,
    LDS_CH_USED   = 2'h3
  } lds_class_e;

  // Comparator outputs of the LED pins
  typedef struct packed {
    logic [`LDS_NCH-1:0] above_detect;
    logic [`LDS_NCH-1:0] below_short;
    logic [`LDS_NCH-1:0] above_inuse;
  } lds_led_cmp_s;

  // Drives to the analog power stage
  typedef struct packed {
    logic gate_on;
    logic switch_en;
    logic ss_mode;
    logic [`LDS_NCH-1:0] sink_en;
    logic [`LDS_NCH-1:0] fb_mask;
  } lds_drive_s;

endpackage : lds_pkg

`default_nettype wire

//--- design/lds_chan.sv
// Classifier of one LED pin at the end of the detect delay
`timescale 1ns/100ps
`default_nettype none

module lds_chan (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic clear,
  input wire logic sample,
  // Comparators
  input wire logic below_short,
  input wire logic above_inuse,
  // Result
  output lds_pkg::lds_class_e cls
);
  import lds_pkg::*;

  typedef struct packed {
    lds_class_e cls;
  } lds_chan_s;

  lds_chan_s s;
  lds_chan_s next_s;

  always_comb
  begin
    next_s = s;
    if (clear)
      next_s.cls = LDS_CH_NONE;
    else if (sample)
    begin
      if (below_short)
        next_s.cls = LDS_CH_SHORT;
      else if (above_inuse)
        next_s.cls = LDS_CH_USED;
      else
        next_s.cls = LDS_CH_UNUSED;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      s <= '{cls: LDS_CH_NONE};
    else
      s <= next_s;
  end

  assign cls = s.cls;
endmodule : lds_chan

`default_nettype wire

//--- design/lds_seq.sv
// Power-up, LED detect and disconnect-switch fault sequencer
`timescale 1ns/100ps
`default_nettype none
`include "lds_cfg.svh"

module lds_seq #(
  parameter int unsigned NCH = `LDS_NCH,
  parameter int unsigned FIRST_HIGH_CYC = `LDS_FIRST_HIGH_CYC,
  parameter int unsigned DET_CYC = `LDS_DET_CYC,
  parameter int unsigned GF1_CYC = `LDS_GF1_CYC,
  parameter int unsigned ENLOW_CYC = `LDS_ENLOW_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Host and supply
  input wire logic en_dim_in,
  input wire logic undervoltage_lockout_clear,
  input wire logic freq_set_sync_pin_low,
  // Disconnect switch comparators
  input wire logic gate_at_level,
  input wire logic ocp_1x,
  input wire logic ocp_2x,
  // LED pin comparators
  input wire lds_pkg::lds_led_cmp_s led_cmp,
  input wire logic led_headroom_ok,
  // Power stage drives
  output lds_pkg::lds_drive_s drive,
  // Open-drain fault pin and status
  output logic fault_out,
  output logic fault_oe,
  output logic low_power
);
  import lds_pkg::*;

  localparam int unsigned W = `LDS_TMR_W;
  localparam int DET_MIN = `LDS_DET_MIN_CYC;
  localparam int DET_MAX = `LDS_DET_MAX_CYC;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lds_state_e st;
    logic judge;
    logic short_hold;
    lds_drive_s drv;
    logic fault_out;
    logic fault_oe;
    logic low_power;
  } lds_seq_s;

  lds_seq_s s;
  lds_seq_s next_s;

  logic active;
  logic en_hi_done;
  logic en_lo_done;
  logic ocp1_done;
  logic det_done;
  logic det_run;
  logic sample;
  logic [NCH-1:0] used_vec;
  logic [NCH-1:0] short_vec;
  lds_class_e cls [NCH];

  assign active = (s.st == LDS_GATE) || (s.st == LDS_DETECT) ||
                  (s.st == LDS_SOFT) || (s.st == LDS_RUN);
  assign det_run = (s.st == LDS_DETECT) && !s.judge && !s.short_hold &&
                   (|led_cmp.above_detect);
  assign sample = det_run && det_done;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  lds_tmr #(.W(W), .TERM(W'(FIRST_HIGH_CYC))) u_en_hi (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(en_dim_in && ((s.st == LDS_OFF) || (s.st == LDS_SLEEP))),
    .done(en_hi_done)
  );

  // Counts in every state but sleep, so an enable held low for the full count ends in sleep unless supply lockout forces off
  lds_tmr #(.W(W), .TERM(W'(ENLOW_CYC))) u_en_lo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(!en_dim_in && (s.st != LDS_SLEEP)),
    .done(en_lo_done)
  );

  lds_tmr #(.W(W), .TERM(W'(GF1_CYC))) u_ocp1 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(active && ocp_1x),
    .done(ocp1_done)
  );

  lds_tmr #(.W(W), .TERM(W'(DET_CYC))) u_det (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(det_run),
    .done(det_done)
  );

  // ----------------------------------------------------------------
  // Channel classifiers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      lds_chan u_chan (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(s.st == LDS_OFF),
        .sample(sample),
        .below_short(led_cmp.below_short[g]),
        .above_inuse(led_cmp.above_inuse[g]),
        .cls(cls[g])
      );
      assign used_vec[g] = (cls[g] == LDS_CH_USED);
      assign short_vec[g] = (cls[g] == LDS_CH_SHORT);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    case (s.st)
      LDS_OFF, LDS_SLEEP:
      begin
        next_s.judge = 1'b0;
        next_s.short_hold = 1'b0;
        if (s.st == LDS_SLEEP && en_dim_in)
          next_s.st = LDS_OFF;
        else if (s.st == LDS_OFF && en_hi_done && undervoltage_lockout_clear && !freq_set_sync_pin_low)
          next_s.st = LDS_GATE;
      end
      LDS_GATE:
        if (gate_at_level)
          next_s.st = LDS_DETECT;
      LDS_DETECT:
        if (s.judge)
        begin
          next_s.judge = 1'b0;
          if (|short_vec)
            next_s.short_hold = 1'b1;
          else if (|used_vec)
            next_s.st = LDS_SOFT;
          else
            next_s.st = LDS_FAULT;
        end
        else if (s.short_hold)
        begin
          // Released pins rerun the whole delay before soft start
          if (!(|(short_vec & led_cmp.below_short)))
            next_s.short_hold = 1'b0;
        end
        else if (sample)
          next_s.judge = 1'b1;
      LDS_SOFT:
        if (led_headroom_ok)
          next_s.st = LDS_RUN;
      LDS_RUN:
        next_s.st = LDS_RUN;
      LDS_FAULT:
        if (!en_dim_in)
          next_s.st = LDS_OFF;
      default:
        next_s.st = LDS_OFF;
    endcase

    // Fast trip bypasses the filter; the slow one needs its full count
    if (active && (ocp_2x || ocp1_done))
      next_s.st = LDS_FAULT;
    if (en_lo_done && (s.st != LDS_SLEEP))
      next_s.st = LDS_SLEEP;
    if (!undervoltage_lockout_clear)
      next_s.st = LDS_OFF;

    next_s.drv.gate_on = (next_s.st == LDS_GATE) || (next_s.st == LDS_DETECT) ||
                         (next_s.st == LDS_SOFT) || (next_s.st == LDS_RUN);
    next_s.drv.switch_en = (next_s.st == LDS_SOFT) || (next_s.st == LDS_RUN);
    next_s.drv.ss_mode = (next_s.st == LDS_SOFT);
    next_s.drv.sink_en = next_s.drv.switch_en ? used_vec : '0;
    next_s.drv.fb_mask = next_s.drv.switch_en ? used_vec : '0;
    next_s.fault_out = 1'b0;
    next_s.fault_oe = (next_s.st == LDS_FAULT);
    next_s.low_power = (next_s.st == LDS_SLEEP);
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      s <= '{st: LDS_OFF, drv: '0, default: 1'b0};
    else
      s <= next_s;
  end

  assign drive = s.drv;
  assign fault_out = s.fault_out;
  assign fault_oe = s.fault_oe;
  assign low_power = s.low_power;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [W-1:0] det_chk;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      det_chk <= '0;
    else if (!det_run)
      det_chk <= '0;
    else if (det_chk != '1)
      det_chk <= det_chk + W'(1);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_start_needs_en: assert property (
    (s.st == LDS_OFF) ##1 (s.st == LDS_GATE) |->
      $past(en_hi_done && undervoltage_lockout_clear && !freq_set_sync_pin_low))
    else $error("power-up began without enable, supply or sync pin clear");

  a_gate_before_detect: assert property (
    (s.st == LDS_GATE) && !gate_at_level && undervoltage_lockout_clear && !ocp_2x && !ocp1_done &&
      !en_lo_done |=> (s.st == LDS_GATE) && drive.gate_on)
    else $error("detect began before the gate reached its level");

  a_sink_after_check: assert property (
    (|drive.sink_en) |-> $past(s.st == LDS_DETECT || s.st == LDS_SOFT || s.st == LDS_RUN))
    else $error("LED sink enabled without a finished check");

  a_sample_delay: assert property (
    sample |-> (det_chk >= DET_MIN) && (det_chk <= DET_MAX))
    else $error("LED status sampled outside the detect delay window");

  a_short_holds: assert property (
    (s.st == LDS_DETECT) && s.short_hold && undervoltage_lockout_clear && !ocp_2x && !ocp1_done &&
      !en_lo_done |=> (s.st == LDS_DETECT) && !drive.switch_en)
    else $error("soft start began while an LED pin was shorted");

  a_unused_no_fb: assert property (
    (s.st == LDS_RUN) |-> ((drive.fb_mask & ~used_vec) == '0) &&
      ((drive.sink_en & ~used_vec) == '0))
    else $error("unused channel takes part in regulation");

  a_fast_trip: assert property (
    active && ocp_2x && undervoltage_lockout_clear && !en_lo_done |-> ##[1:2] (s.st == LDS_FAULT))
    else $error("twice-trip overcurrent did not shut down in time");

  a_slow_filter: assert property (
    (s.st == LDS_RUN) && ocp_1x && !ocp_2x && !ocp1_done && undervoltage_lockout_clear && !en_lo_done
      |=> (s.st == LDS_RUN))
    else $error("filtered overcurrent shut down before its count");

  a_fault_outputs: assert property (
    (s.st == LDS_FAULT) |-> !drive.gate_on && !drive.switch_en &&
      (drive.sink_en == '0) && fault_oe && !fault_out)
    else $error("fault state left a drive on or fault pin released");

  a_sleep_count: assert property (
    en_lo_done && (s.st != LDS_SLEEP) && undervoltage_lockout_clear |=> low_power && !drive.gate_on)
    else $error("enable low count did not end in shutdown");

  a_soft_reduced: assert property (
    (s.st == LDS_SOFT) && led_headroom_ok && undervoltage_lockout_clear && !ocp_2x && !ocp1_done &&
      !en_lo_done |-> drive.ss_mode ##1 (s.st == LDS_RUN) && !drive.ss_mode)
    else $error("soft start mode wrong around headroom");

endmodule : lds_seq

`default_nettype wire

//--- design/lds_tmr.sv
// Saturating cycle counter with run and clear
`timescale 1ns/100ps
`default_nettype none

module lds_tmr #(
  parameter int unsigned W = 16,
  parameter logic [W-1:0] TERM = '1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic run,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } lds_tmr_s;

  lds_tmr_s s;
  lds_tmr_s next_s;

  // Dropping run clears, so only consecutive cycles count
  always_comb
  begin
    next_s = s;
    if (!run)
      next_s.cnt = '0;
    else if (s.cnt != TERM)
      next_s.cnt = s.cnt + W'(1);
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign done = (s.cnt == TERM);
endmodule : lds_tmr

`default_nettype wire

//--- dv/lds_afe_model.sv
// Behavioural model of the comparators and gate around the sequencer
`timescale 1ns/100ps
`default_nettype none

module lds_afe_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Scenario setup, bit per channel
  input wire logic [1:0] short_mask,
  input wire logic [1:0] used_mask,
  // Power stage view
  input wire lds_pkg::lds_drive_s drive,
  // Comparator outputs
  output logic gate_at_level,
  output lds_pkg::lds_led_cmp_s led_cmp,
  output logic led_headroom_ok
);
  import lds_pkg::*;

  // Gate takes a few cycles to come up to its level, as a real switch does
  logic [2:0] gate_dly;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      gate_dly <= 3'h0;
      gate_at_level <= 1'b0;
      led_cmp <= '0;
      led_headroom_ok <= 1'b0;
    end
    else
    begin
      gate_dly <= {gate_dly[1:0], drive.gate_on};
      gate_at_level <= gate_dly[2] & drive.gate_on;
      // Shorted pin never rises, so it shows only below the short level
      led_cmp.above_detect <= {2{gate_at_level}} & ~short_mask;
      led_cmp.below_short <= {2{drive.gate_on}} & short_mask;
      led_cmp.above_inuse <= {2{gate_at_level}} & used_mask & ~short_mask;
      led_headroom_ok <= drive.ss_mode;
    end
  end
endmodule : lds_afe_model

`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench of the power-up and fault sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import lds_pkg::*;
  localparam int ENL = 40;
  localparam int GF1 = 20;
  logic clk_sys, resetn, en_dim_in, undervoltage_lockout_clear, sync_low, gate_at_level;
  logic ocp_1x, ocp_2x, led_headroom_ok, fault_out, fault_oe, low_power;
  logic [1:0] short_mask, used_mask;
  lds_led_cmp_s led_cmp;
  lds_drive_s drive;
  int n_fail, comparisons, seed, k, i;

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  lds_seq #(.ENLOW_CYC(ENL), .GF1_CYC(GF1)) dut (.clk_sys(clk_sys), .resetn(resetn),
    .en_dim_in(en_dim_in), .undervoltage_lockout_clear(undervoltage_lockout_clear), .freq_set_sync_pin_low(sync_low),
    .gate_at_level(gate_at_level), .ocp_1x(ocp_1x), .ocp_2x(ocp_2x), .led_cmp(led_cmp),
    .led_headroom_ok(led_headroom_ok), .drive(drive), .fault_out(fault_out),
    .fault_oe(fault_oe), .low_power(low_power));

  lds_afe_model afe (.clk_sys(clk_sys), .resetn(resetn), .short_mask(short_mask),
    .used_mask(used_mask), .drive(drive), .gate_at_level(gate_at_level),
    .led_cmp(led_cmp), .led_headroom_ok(led_headroom_ok));

  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // Inputs always move 2 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc

  function automatic logic sel(input int w);
    case (w)
      0: return drive.gate_on;
      1: return drive.switch_en;
      2: return fault_oe;
      3: return low_power;
      default: return ~drive.ss_mode;
    endcase
  endfunction : sel

  task automatic wait_sig(input int w, input int lim, output int n);
    n = 0;
    while (sel(w) !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
    if (n >= lim)
    begin
      n_fail++;
      $display("ERROR t=%0t wait %0h gave up", $time, w);
      results();
    end
  endtask : wait_sig

  task automatic restart(input logic [1:0] used, input logic [1:0] shrt);
    resetn = 1'b0;
    en_dim_in = 1'b0;
    undervoltage_lockout_clear = 1'b1;
    sync_low = 1'b0;
    ocp_1x = 1'b0;
    ocp_2x = 1'b0;
    used_mask = used;
    short_mask = shrt;
    cyc(20);
    resetn = 1'b1;
    cyc(2);
    en_dim_in = 1'b1;
  endtask : restart

  // Called at the gate-on edge; k then spans the whole detect phase
  task automatic bring_up(input logic [1:0] used);
    wait_sig(1, 4200, k);
    chk(8'(k >= 3000 && k <= 4100), 8'h01);
    chk(8'(drive.ss_mode), 8'h01);
    chk(8'(drive.sink_en), 8'(used));
    chk(8'(drive.fb_mask), 8'(used));
    wait_sig(4, 10, k);
    chk(8'({drive.switch_en, drive.sink_en}), 8'({1'b1, used}));
  endtask : bring_up

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 58232;
    n_fail = 0;
    comparisons = 0;
    restart(2'h3, 2'h0);
    sync_low = 1'b1;
    chk(8'({fault_oe, drive}), 8'h00);
    cyc(100);
    chk(8'(drive.gate_on), 8'h00);
    sync_low = 1'b0;
    undervoltage_lockout_clear = 1'b0;
    cyc(100);
    chk(8'(drive.gate_on), 8'h00);
    en_dim_in = 1'b0;
    cyc(1);
    en_dim_in = 1'b1;
    undervoltage_lockout_clear = 1'b1;
    wait_sig(0, 80, k);
    chk(8'(k >= 50 && k <= 54), 8'h01);
    bring_up(2'h3);
    // Supply loss drops every drive without a fault
    undervoltage_lockout_clear = 1'b0;
    cyc(2);
    chk(8'({fault_oe, drive}), 8'h00);
    // Shorted pin halts, release resumes
    restart(2'h3, 2'h1);
    wait_sig(0, 80, k);
    cyc(4500);
    chk(8'({drive.switch_en, drive.sink_en}), 8'h00);
    short_mask = 2'h0;
    wait_sig(1, 4200, k);
    chk(8'(drive.sink_en), 8'h03);
    // No pin in use never enables a sink
    restart(2'h0, 2'h0);
    wait_sig(0, 80, k);
    wait_sig(2, 4200, k);
    chk(8'(drive), 8'h00);
    for (i = 0; i < 4; i++)
    begin
      restart(i == 0 ? 2'h2 : 2'((($random(seed) & 32'h7FFF) % 3) + 1), 2'h0);
      wait_sig(0, 80, k);
      bring_up(used_mask);
      if (i % 2 == 1)
      begin
        ocp_1x = 1'b1;
        cyc(1 + ($random(seed) & 32'hF));
        ocp_1x = 1'b0;
        cyc(2);
        chk(8'(fault_oe), 8'h00);
        ocp_1x = 1'b1;
        wait_sig(2, GF1 + 10, k);
        chk(8'(k >= GF1 && k <= GF1 + 3), 8'h01);
      end
      else
      begin
        en_dim_in = 1'b0;
        cyc(ENL - 10);
        en_dim_in = 1'b1;
        cyc(2);
        chk(8'(low_power), 8'h00);
        ocp_2x = 1'b1;
        wait_sig(2, 75, k);
      end
      ocp_1x = 1'b0;
      ocp_2x = 1'b0;
      cyc(30);
      chk(8'({fault_oe, drive}), 8'h80);
      chk(8'(fault_out), 8'h00);
      // Host holds enable low for the shutdown count
      en_dim_in = 1'b0;
      wait_sig(3, ENL + 10, k);
      chk(8'({k >= ENL - 1 && k <= ENL + 3, fault_oe}), 8'h02);
    end
    // Wake from shutdown needs the full first-pulse time again
    en_dim_in = 1'b1;
    wait_sig(0, 80, k);
    chk(8'({k >= 50 && k <= 54, low_power}), 8'h02);
    results();
  end
endmodule : tb_top

`default_nettype wire
